// ===== ccr_pkg.sv
package ccr_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [31:0] CCR_CTRL_ADDR = 32'h0000_0000;
  localparam logic [31:0] CCR_STAT_ADDR = 32'h0000_0004;
  localparam logic [15:0] CCR_CTRL_RESET = 16'h0020;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CCR_VAR_BIT = 15;
  localparam int CCR_UNUSED_BIT = 14;
  localparam int CCR_US_HI = 13;
  localparam int CCR_US_LO = 12;
  localparam int CCR_EXIT_BIT = 11;
  localparam int CCR_DL_HI = 10;
  localparam int CCR_DL_LO = 8;
  localparam int CCR_SAT_FIRST_ACC_ENABLE_BIT = 7;
  localparam int CCR_SAT_SECOND_ACC_ENABLE_BIT = 6;
  localparam int CCR_STORE_SATURATION_ENABLE_BIT = 5;
  localparam int CCR_SATMODE_BIT = 4;
  localparam int CCR_IPLMSB_BIT = 3;
  // writable bits: 15, 13, 12, 7, 6, 5, 4 and the low three bits
  localparam logic [15:0] CCR_WMASK = 16'hB0F7;
  // ----------------------------------------------------------------
  // multiply operand modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CCR_MUL_SIGNED = 2'h0,
    CCR_MUL_UNSIGNED = 2'h1,
    CCR_MUL_MIXED = 2'h2,
    CCR_MUL_RSVD = 2'h3
  } ccr_mul_t;
endpackage : ccr_pkg

// ===== ccr_wb_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ccr_wb_if;
  logic wr;
  logic rd;
  logic [31:0] addr;
  logic [15:0] wdata;
  logic [1:0] sel;
  modport slave (output wr, output rd, output addr, output wdata, output sel);
  modport regs (input wr, input rd, input addr, input wdata, input sel);
endinterface : ccr_wb_if
`default_nettype wire

// ===== ccr_wb_slave.sv
`timescale 1ns/1ps
`default_nettype none
module ccr_wb_slave (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic cyc_in,
  input wire logic stb_in,
  input wire logic we_in,
  input wire logic [31:0] adr_in,
  input wire logic [3:0] sel_in,
  input wire logic [31:0] dat_in,
  output logic ack_out,
  ccr_wb_if.slave bus
);
  logic ack_q;
  // ----------------------------------------------------------------
  // one-wait-state ack; a write acts on the ack edge only, a read on every request cycle
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      ack_q <= 1'b0;
    end else if (clk_en_in) begin
      ack_q <= cyc_in && stb_in && !ack_q;
    end
  end
  assign ack_out = ack_q;
  assign bus.wr = ack_q && cyc_in && stb_in && we_in && clk_en_in;
  assign bus.rd = cyc_in && stb_in && !we_in;
  assign bus.addr = adr_in;
  assign bus.wdata = dat_in[15:0];
  assign bus.sel = sel_in[1:0];
endmodule : ccr_wb_slave
`default_nettype wire

// ===== ccr_core_control.sv
`timescale 1ns/1ps
`default_nettype none
module ccr_core_control (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [31:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic [2:0] loop_depth_in,
  input wire logic loop_iter_end_in,
  input wire logic priority_level_msb_in,
  input wire logic priority_msb_load_in,
  input wire logic [2:0] priority_level_low_in,
  output logic variable_latency_out,
  output ccr_pkg::ccr_mul_t mult_sign_mode_out,
  output logic early_loop_exit_out,
  output logic sat_first_acc_enable_out,
  output logic sat_second_acc_enable_out,
  output logic store_saturation_enable_out,
  output logic saturation_mode_out,
  output logic [3:0] cpu_priority_level_out,
  output logic [2:0] core_low_bits_out
);
  import ccr_pkg::*;

  ccr_wb_if bus ();
  logic [15:0] ctrl_q;
  logic exit_pend_q;
  logic exit_pulse_q;
  logic ipl_msb_q;
  logic [31:0] rdata_q;
  logic [15:0] word_d;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  ccr_wb_slave u_slave (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .cyc_in(wb_cyc_in),
    .stb_in(wb_stb_in),
    .we_in(wb_we_in),
    .adr_in(wb_adr_in),
    .sel_in(wb_sel_in),
    .dat_in(wb_dat_in),
    .ack_out(wb_ack_out),
    .bus(bus)
  );

  function automatic logic [15:0] merge_lanes(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic [1:0] sel);
    logic [15:0] m;
    m = {{8{sel[1]}}, {8{sel[0]}}} & CCR_WMASK;
    merge_lanes = (old_v & ~m) | (new_v & m);
  endfunction : merge_lanes

  // address decode shared by the write strobe and the read mux
  function automatic logic addr_hit(input logic [31:0] adr,
                                    input logic [31:0] base);
    addr_hit = (adr == base);
  endfunction : addr_hit

  logic ctrl_wr;
  logic ctrl_rd;
  logic stat_rd;
  assign ctrl_wr = bus.wr && addr_hit(bus.addr, CCR_CTRL_ADDR);
  assign ctrl_rd = bus.rd && addr_hit(bus.addr, CCR_CTRL_ADDR);
  assign stat_rd = bus.rd && addr_hit(bus.addr, CCR_STAT_ADDR);

  // ----------------------------------------------------------------
  // writable fields
  // ----------------------------------------------------------------
  // bit 14, bit 11, status bits never enter ctrl_q
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl_q <= CCR_CTRL_RESET;
    end else if (clk_en_in && ctrl_wr) begin
      ctrl_q <= merge_lanes(ctrl_q, bus.wdata, bus.sel);
    end
  end

  // ----------------------------------------------------------------
  // early loop exit
  // ----------------------------------------------------------------
  // request is held until the loop logic reports the iteration end or the loop depth reads zero
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      exit_pend_q <= 1'b0;
    end else if (clk_en_in) begin
      if (ctrl_wr && bus.sel[1] && bus.wdata[CCR_EXIT_BIT]) begin
        exit_pend_q <= 1'b1;
      end else if (loop_iter_end_in || loop_depth_in == 3'h0) begin
        exit_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      exit_pulse_q <= 1'b0;
    end else if (clk_en_in) begin
      exit_pulse_q <= exit_pend_q && loop_iter_end_in && loop_depth_in != 3'h0;
    end
  end

  // ----------------------------------------------------------------
  // priority top bit, loaded only by core hardware
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      ipl_msb_q <= 1'b0;
    end else if (clk_en_in && priority_msb_load_in) begin
      ipl_msb_q <= priority_level_msb_in;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    word_d = ctrl_q;
    word_d[CCR_UNUSED_BIT] = 1'b0;
    word_d[CCR_EXIT_BIT] = 1'b0;
    word_d[CCR_DL_HI:CCR_DL_LO] = loop_depth_in;
    word_d[CCR_IPLMSB_BIT] = ipl_msb_q;
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (clk_en_in) begin
      if (ctrl_rd) begin
        rdata_q <= {16'h0000, word_d};
      end else if (stat_rd) begin
        rdata_q <= {28'h000_0000, ipl_msb_q, priority_level_low_in};
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end
  assign wb_dat_out = rdata_q;

  // ----------------------------------------------------------------
  // field outputs
  // ----------------------------------------------------------------
  assign variable_latency_out = ctrl_q[CCR_VAR_BIT];
  assign mult_sign_mode_out = ccr_mul_t'(ctrl_q[CCR_US_HI:CCR_US_LO]);
  assign early_loop_exit_out = exit_pulse_q;
  assign sat_first_acc_enable_out = ctrl_q[CCR_SAT_FIRST_ACC_ENABLE_BIT];
  assign sat_second_acc_enable_out = ctrl_q[CCR_SAT_SECOND_ACC_ENABLE_BIT];
  assign store_saturation_enable_out = ctrl_q[CCR_STORE_SATURATION_ENABLE_BIT];
  assign saturation_mode_out = ctrl_q[CCR_SATMODE_BIT];
  assign cpu_priority_level_out = {ipl_msb_q, priority_level_low_in};
  assign core_low_bits_out = ctrl_q[2:0];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_exit_reads_zero;
    @(posedge mclk_in) disable iff (reset_in) wb_ack_out |-> !wb_dat_out[CCR_EXIT_BIT];
  endproperty
  a_exit_reads_zero: assert property (p_exit_reads_zero) else $error("exit bit read one");

  property p_unused_zero;
    @(posedge mclk_in) disable iff (reset_in) !wb_dat_out[CCR_UNUSED_BIT];
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("bit 14 read one");

  property p_depth_read;
    @(posedge mclk_in) disable iff (reset_in)
      (clk_en_in && bus.rd && bus.addr == CCR_CTRL_ADDR)
      |=> wb_dat_out[CCR_DL_HI:CCR_DL_LO] == $past(loop_depth_in);
  endproperty
  a_depth_read: assert property (p_depth_read) else $error("loop depth mismatch");

  property p_msb_read;
    @(posedge mclk_in) disable iff (reset_in)
      (clk_en_in && bus.rd && bus.addr == CCR_CTRL_ADDR)
      |=> wb_dat_out[CCR_IPLMSB_BIT] == $past(ipl_msb_q);
  endproperty
  a_msb_read: assert property (p_msb_read) else $error("priority top bit read wrong");

  property p_msb_no_sw;
    @(posedge mclk_in) disable iff (reset_in)
      !priority_msb_load_in |=> $stable(ipl_msb_q);
  endproperty
  a_msb_no_sw: assert property (p_msb_no_sw) else $error("priority bit changed");

  property p_level;
    @(posedge mclk_in) disable iff (reset_in)
      cpu_priority_level_out[2:0] == priority_level_low_in
      && cpu_priority_level_out[3] == ipl_msb_q;
  endproperty
  a_level: assert property (p_level) else $error("priority level wrong");

  sequence s_exit_req;
    clk_en_in && ctrl_wr && bus.sel[1] && bus.wdata[CCR_EXIT_BIT] && loop_depth_in != 3'h0;
  endsequence
  sequence s_iter_end;
    clk_en_in && loop_iter_end_in && loop_depth_in != 3'h0;
  endsequence
  property p_exit_fires;
    @(posedge mclk_in) disable iff (reset_in)
      s_exit_req ##1 s_iter_end |=> early_loop_exit_out;
  endproperty
  a_exit_fires: assert property (p_exit_fires) else $error("loop exit missed");

  property p_no_exit_idle;
    @(posedge mclk_in) disable iff (reset_in)
      (clk_en_in && !exit_pend_q) |=> !early_loop_exit_out;
  endproperty
  a_no_exit_idle: assert property (p_no_exit_idle) else $error("spurious loop exit");

  property p_write_keeps;
    @(posedge mclk_in) disable iff (reset_in)
      (clk_en_in && ctrl_wr && bus.sel == 2'h3)
      |=> (ctrl_q & CCR_WMASK) == ($past(bus.wdata) & CCR_WMASK);
  endproperty
  a_write_keeps: assert property (p_write_keeps) else $error("write not stored");

  property p_sat_follows;
    @(posedge mclk_in) disable iff (reset_in)
      store_saturation_enable_out == ctrl_q[CCR_STORE_SATURATION_ENABLE_BIT]
      && saturation_mode_out == ctrl_q[CCR_SATMODE_BIT];
  endproperty
  a_sat_follows: assert property (p_sat_follows) else $error("saturation outputs wrong");

  sequence s_write_hi;
    clk_en_in && ctrl_wr && bus.sel[1];
  endsequence
  sequence s_write_lo;
    clk_en_in && ctrl_wr && bus.sel[0];
  endsequence

  property p_var_write;
    @(posedge mclk_in) disable iff (reset_in)
      s_write_hi |=> variable_latency_out == $past(bus.wdata[CCR_VAR_BIT]);
  endproperty
  a_var_write: assert property (p_var_write) else $error("latency mode not stored");

  property p_mode_write;
    @(posedge mclk_in) disable iff (reset_in)
      s_write_hi |=> mult_sign_mode_out == $past(bus.wdata[CCR_US_HI:CCR_US_LO]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("multiply mode not stored");

  property p_sat_first_acc_enable_write;
    @(posedge mclk_in) disable iff (reset_in)
      s_write_lo |=> sat_first_acc_enable_out == $past(bus.wdata[CCR_SAT_FIRST_ACC_ENABLE_BIT]);
  endproperty
  a_sat_first_acc_enable_write: assert property (p_sat_first_acc_enable_write) else $error("first acc enable wrong");

  property p_sat_second_acc_enable_write;
    @(posedge mclk_in) disable iff (reset_in)
      s_write_lo |=> sat_second_acc_enable_out == $past(bus.wdata[CCR_SAT_SECOND_ACC_ENABLE_BIT]);
  endproperty
  a_sat_second_acc_enable_write: assert property (p_sat_second_acc_enable_write) else $error("second acc enable wrong");

  property p_store_saturation_enable_write;
    @(posedge mclk_in) disable iff (reset_in)
      s_write_lo |=> store_saturation_enable_out == $past(bus.wdata[CCR_STORE_SATURATION_ENABLE_BIT]);
  endproperty
  a_store_saturation_enable_write: assert property (p_store_saturation_enable_write) else $error("store enable wrong");

  property p_satmode_write;
    @(posedge mclk_in) disable iff (reset_in)
      s_write_lo |=> saturation_mode_out == $past(bus.wdata[CCR_SATMODE_BIT]);
  endproperty
  a_satmode_write: assert property (p_satmode_write) else $error("sat mode wrong");

  property p_keep_hi;
    @(posedge mclk_in) disable iff (reset_in)
      (clk_en_in && ctrl_wr && !bus.sel[1]) |=> ctrl_q[15:8] == $past(ctrl_q[15:8]);
  endproperty
  a_keep_hi: assert property (p_keep_hi) else $error("upper lane changed");

  property p_keep_lo;
    @(posedge mclk_in) disable iff (reset_in)
      (clk_en_in && ctrl_wr && !bus.sel[0]) |=> ctrl_q[7:0] == $past(ctrl_q[7:0]);
  endproperty
  a_keep_lo: assert property (p_keep_lo) else $error("lower lane changed");

  property p_idle_keeps;
    @(posedge mclk_in) disable iff (reset_in)
      (clk_en_in && !ctrl_wr) |=> $stable(ctrl_q);
  endproperty
  a_idle_keeps: assert property (p_idle_keeps) else $error("control word changed");

  property p_unused_never_set;
    @(posedge mclk_in) disable iff (reset_in) !ctrl_q[CCR_UNUSED_BIT] && !ctrl_q[CCR_EXIT_BIT];
  endproperty
  a_unused_never_set: assert property (p_unused_never_set) else $error("bit stored");

  // checked without a disable so that the released state itself is seen
  property p_reset_value;
    @(posedge mclk_in)
      $fell(reset_in) |-> ctrl_q == CCR_CTRL_RESET && !ipl_msb_q && !wb_ack_out;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("reset value wrong");

  property p_ack_once;
    @(posedge mclk_in) disable iff (reset_in)
      (clk_en_in && wb_ack_out) |=> !wb_ack_out;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held high");

  property p_ack_answer;
    @(posedge mclk_in) disable iff (reset_in)
      (clk_en_in && wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("ack late");

  property p_status_read;
    @(posedge mclk_in) disable iff (reset_in)
      (clk_en_in && stat_rd)
      |=> wb_dat_out == {28'h000_0000, $past(ipl_msb_q), $past(priority_level_low_in)};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status word wrong");

  property p_unmapped_read;
    @(posedge mclk_in) disable iff (reset_in)
      (clk_en_in && bus.rd && !ctrl_rd && !stat_rd) |=> wb_dat_out == 32'h0000_0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read data");

  property p_dat_idle;
    @(posedge mclk_in) disable iff (reset_in)
      (clk_en_in && !wb_cyc_in) |=> wb_dat_out == 32'h0000_0000;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data left standing");

  property p_exit_single;
    @(posedge mclk_in) disable iff (reset_in)
      (clk_en_in && early_loop_exit_out) |=> !early_loop_exit_out;
  endproperty
  a_exit_single: assert property (p_exit_single) else $error("loop exit pulse too long");
endmodule : ccr_core_control
`default_nettype wire

// ===== ccr_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccr_core_model (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic [2:0] depth_cmd_in,
  input wire logic iter_cmd_in,
  input wire logic [3:0] level_cmd_in,
  output logic [2:0] loop_depth_out,
  output logic loop_iter_end_out,
  output logic priority_level_msb_out,
  output logic priority_msb_load_out,
  output logic [2:0] priority_level_low_out
);
  // ------------------------------------------------------------
  // core side: status fields come only from here, never from software
  // ------------------------------------------------------------
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      loop_depth_out <= 3'h0;
      loop_iter_end_out <= 1'b0;
      priority_level_msb_out <= 1'b0;
      priority_msb_load_out <= 1'b0;
      priority_level_low_out <= 3'h0;
    end else begin
      loop_depth_out <= depth_cmd_in;
      loop_iter_end_out <= iter_cmd_in;
      priority_level_low_out <= level_cmd_in[2:0];
      priority_level_msb_out <= level_cmd_in[3];
      priority_msb_load_out <= 1'b1;
    end
  end
endmodule : ccr_core_model
`default_nettype wire

// ===== core_control_register_test.sv
`timescale 1ns/1ps
`default_nettype none
module core_control_register_test;
  import ccr_pkg::*;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, iter = 0;
  logic [31:0] adr = 0, wdat = 0, rdat;
  logic [3:0] sel = 0, lvl = 0, prio;
  logic [2:0] dep = 0, ldep, plow, lowb;
  logic lend, pmsb, pld, vlat, exitp, sa, sb, sd, sm;
  ccr_mul_t mmode;
  logic [15:0] r;
  int mismatches = 0, n_checks = 0;
  always #25 clk = ~clk;
  ccr_core_model i_ccr_core_model (.mclk_in(clk), .reset_in(rst), .depth_cmd_in(dep),
    .iter_cmd_in(iter), .level_cmd_in(lvl), .loop_depth_out(ldep), .loop_iter_end_out(lend),
    .priority_level_msb_out(pmsb), .priority_msb_load_out(pld), .priority_level_low_out(plow));
  ccr_core_control i_ccr_core_control (.mclk_in(clk), .reset_in(rst), .clk_en_in(1'b1),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .loop_depth_in(ldep),
    .loop_iter_end_in(lend), .priority_level_msb_in(pmsb), .priority_msb_load_in(pld),
    .priority_level_low_in(plow), .variable_latency_out(vlat), .mult_sign_mode_out(mmode),
    .early_loop_exit_out(exitp), .sat_first_acc_enable_out(sa), .sat_second_acc_enable_out(sb),
    .store_saturation_enable_out(sd), .saturation_mode_out(sm), .cpu_priority_level_out(prio),
    .core_low_bits_out(lowb));
  // ------------------------------------------------------------
  // bus cycle and comparison
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [31:0] a, input logic [15:0] d,
                     input logic [1:0] s);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {16'h0000, d}; sel <= {2'h0, s};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    r = rdat[15:0];
    if (n >= 40) chk(16'hDEAD, 16'h0000);
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : bus
  task automatic pulses(output int c);
    c = 0;
    @(posedge clk) iter <= 1'b1;
    @(posedge clk) iter <= 1'b0;
    repeat (6) @(posedge clk) if (exitp === 1'b1) c++;
  endtask : pulses
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_fields;
    bus(0, CCR_CTRL_ADDR, 0, 3); chk(r, CCR_CTRL_RESET);
    chk({15'h0, sd}, 16'h0001);
    bus(1, CCR_CTRL_ADDR, 16'hFFFF, 3); bus(0, CCR_CTRL_ADDR, 0, 3);
    chk(r, 16'hB0F7);
    chk({11'h0, vlat, sa, sb, sd, sm}, 16'h001F);
    chk({13'h0, lowb}, 16'h0007);
    bus(1, CCR_CTRL_ADDR, 16'h0000, 3); bus(0, CCR_CTRL_ADDR, 0, 3);
    chk(r, 16'h0000);
    chk({11'h0, vlat, sa, sb, sd, sm}, 16'h0000);
    bus(1, CCR_CTRL_ADDR, 16'hFFFF, 1); bus(0, CCR_CTRL_ADDR, 0, 3);
    chk(r, 16'h00F7);
    bus(1, CCR_CTRL_ADDR, 16'hFFFF, 2); bus(0, CCR_CTRL_ADDR, 0, 3);
    chk(r, 16'hB0F7);
    for (int i = 0; i < 4; i++) begin
      bus(1, CCR_CTRL_ADDR, 16'(i) << 12, 3);
      @(posedge clk);
      chk({14'h0, mmode}, 16'(i));
    end
  endtask : t_fields
  task automatic t_loop;
    int c;
    dep <= 3'h7;
    bus(0, CCR_CTRL_ADDR, 0, 3); chk(r, 16'h3700);
    dep <= 3'h5;
    bus(1, CCR_CTRL_ADDR, 16'h0800, 3); bus(0, CCR_CTRL_ADDR, 0, 3);
    chk(r, 16'h0500);
    pulses(c); chk(16'(c), 16'h0001);
    bus(1, CCR_CTRL_ADDR, 16'h0000, 3);
    pulses(c); chk(16'(c), 16'h0000);
    dep <= 3'h0;
  endtask : t_loop
  // iteration end lands on the edge right after the exit write
  task automatic t_exit_race;
    int c;
    c = 0;
    @(posedge clk);
    dep <= 3'h3;
    @(posedge clk);
    fork
      bus(1, CCR_CTRL_ADDR, 16'h0800, 3);
      begin
        repeat (2) @(posedge clk);
        iter <= 1'b1;
        @(posedge clk);
        iter <= 1'b0;
      end
    join
    repeat (6) @(posedge clk) if (exitp === 1'b1) c++;
    chk(16'(c), 16'h0001);
    dep <= 3'h0;
  endtask : t_exit_race
  task automatic t_prio;
    lvl <= 4'hA;
    repeat (2) @(posedge clk);
    bus(0, CCR_CTRL_ADDR, 0, 3); chk(r, 16'h0008);
    chk({12'h0, prio}, 16'h000A);
    bus(0, CCR_STAT_ADDR, 0, 3);
    chk(r, 16'h000A);
    bus(1, CCR_CTRL_ADDR, 16'h0000, 3); bus(0, CCR_CTRL_ADDR, 0, 3);
    chk(r, 16'h0008);
    lvl <= 4'h7;
    repeat (2) @(posedge clk);
    bus(0, CCR_CTRL_ADDR, 0, 3); chk(r, 16'h0000);
    bus(1, CCR_CTRL_ADDR, 16'h0008, 3); bus(0, CCR_CTRL_ADDR, 0, 3);
    chk(r, 16'h0000);
    chk({12'h0, prio}, 16'h0007);
  endtask : t_prio
  task automatic t_unmapped;
    bus(1, 32'h0000_0008, 16'hFFFF, 3); bus(0, 32'h0000_0008, 0, 3);
    chk(r, 16'h0000);
    bus(0, CCR_CTRL_ADDR, 0, 3); chk(r, 16'h0000);
  endtask : t_unmapped
  task automatic t_reset;
    bus(1, CCR_CTRL_ADDR, 16'hFFFF, 3);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(0, CCR_CTRL_ADDR, 0, 3);
    chk(r, CCR_CTRL_RESET);
    chk({15'h0, sd}, 16'h0001);
  endtask : t_reset
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_fields;
    t_loop;
    t_exit_race;
    t_prio;
    t_unmapped;
    t_reset;
    print_verdict;
  end
  // a stall outside the bus waits, which give up after 40 cycles, would otherwise hang the run
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    print_verdict;
  end
endmodule : core_control_register_test
`default_nettype wire
